// ===== hw/pefr_defs.svh
`ifndef PEFR_DEFS_SVH
`define PEFR_DEFS_SVH

// register map, byte addresses on the avalon word bus
`define PEFR_FLAGS_ADDR 4'h0
`define PEFR_RXDATA_ADDR 4'h4
`define PEFR_TXDATA_ADDR 4'h8
`define PEFR_ADDR_W 4

// flag bit positions
`define PEFR_BIT_GATE 7
`define PEFR_BIT_CONV 6
`define PEFR_BIT_RXFULL 5
`define PEFR_BIT_TXEMPTY 4
`define PEFR_BIT_SERIAL 3
`define PEFR_BIT_CAPCMP 2
`define PEFR_BIT_PERIOD 1
`define PEFR_BIT_OVERFLOW 0

`define PEFR_FLAGS_RESET 8'h00
`define PEFR_RW_MASK 8'hCF
`define PEFR_UNMAPPED_DATA 32'h00000000

`endif

// ===== hw/pefr_pkg.sv
package pefr_pkg;
    typedef enum logic [2:0] {
        CCP_CAPTURE = 3'b001,
        CCP_COMPARE = 3'b010,
        CCP_PWM = 3'b100
    } pefr_ccp_mode_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_ACK = 3'b010,
        BUS_HOLD = 3'b100
    } pefr_bus_state_t;
endpackage : pefr_pkg

// ===== hw/pefr_flag_bit.sv
`timescale 1ns/100ps
`default_nettype none
module pefr_flag_bit (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic setEvent,
    input wire logic clearReq,
    output logic flag
);
    logic flag_q;
    logic flag_d;

    // set wins over a coincident clear
    assign flag_d = setEvent ? 1'b1 : (clearReq ? 1'b0 : flag_q);
    assign flag = flag_q;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            flag_q <= 1'b0;
        end else if (clkEn) begin
            flag_q <= flag_d;
        end
    end
endmodule : pefr_flag_bit
`default_nettype wire

// ===== hw/pefr_edge_detect.sv
`timescale 1ns/100ps
`default_nettype none
module pefr_edge_detect (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic level,
    output logic fallPulse
);
    logic level_q;

    // history starts low so no false fall right after reset
    assign fallPulse = clkEn & level_q & ~level;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            level_q <= 1'b0;
        end else if (clkEn) begin
            level_q <= level;
        end
    end
endmodule : pefr_edge_detect
`default_nettype wire

// ===== hw/pefr_flags.sv
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "pefr_defs.svh"
module pefr_flags (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic gateValue,
    input wire logic conversionDone,
    input wire logic serialPortDone,
    input wire pefr_pkg::pefr_ccp_mode_t ccpMode,
    input wire logic captureEvent,
    input wire logic compareMatch,
    input wire logic periodMatch,
    input wire logic counterOverflow,
    input wire logic rxDataReady,
    input wire logic [7:0] rxDataIn,
    output logic rxDataTaken,
    output logic txDataValid,
    output logic [7:0] txDataOut,
    input wire logic txDataTaken,
    output logic [7:0] flagsOut
);
    pefr_pkg::pefr_bus_state_t busState_q;
    pefr_pkg::pefr_bus_state_t busState_d;
    logic [31:0] readData_q;
    logic waitReq_q;
    logic rxFull_q;
    logic [7:0] rxBuf_q;
    logic txFull_q;
    logic [7:0] txBuf_q;
    logic rxTaken_q;
    logic [7:0] flagsOut_q;
    logic [7:0] rwFlags;
    logic gateFall;
    logic [7:0] setEvents;
    logic [7:0] clearReqs;
    logic [7:0] flagView;

    // a request is taken in the ack state, one cycle after it rises
    wire busReq = avs_read | avs_write;
    wire accept = clkEn & (busState_q == pefr_pkg::BUS_ACK);
    wire selFlags = (avs_address == `PEFR_FLAGS_ADDR);
    wire selRx = (avs_address == `PEFR_RXDATA_ADDR);
    wire selTx = (avs_address == `PEFR_TXDATA_ADDR);
    wire lane0 = avs_byteenable[0];
    wire flagWrite = accept & avs_write & selFlags & lane0;
    wire rxRead = accept & avs_read & selRx;
    wire txWrite = accept & avs_write & selTx & lane0;
    wire ccpSet = (ccpMode == pefr_pkg::CCP_CAPTURE) ? captureEvent :
                  (ccpMode == pefr_pkg::CCP_COMPARE) ? compareMatch : 1'b0;
    wire rxLoad = rxDataReady & (~rxFull_q | rxRead);
    wire txDrain = txFull_q & txDataTaken;

    pefr_edge_detect u_gate_edge (
        .clock(clock),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .level(gateValue),
        .fallPulse(gateFall)
    );

    // events feed flags directly, gated only by clkEn; ccpMode picks the ccp source and blocks it in PWM
    assign setEvents = {gateFall, conversionDone, 1'b0, 1'b0,
                        serialPortDone, ccpSet, periodMatch, counterOverflow};
    // zero written to a rw bit clears it
    assign clearReqs = {8{flagWrite}} & ~avs_writedata[7:0] & `PEFR_RW_MASK;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
            if (gi == `PEFR_BIT_RXFULL || gi == `PEFR_BIT_TXEMPTY) begin : g_ro
                assign rwFlags[gi] = 1'b0;
            end else begin : g_rw
                pefr_flag_bit u_bit (
                    .clock(clock),
                    .rst_b(rst_b),
                    .clkEn(clkEn),
                    .setEvent(setEvents[gi]),
                    .clearReq(clearReqs[gi]),
                    .flag(rwFlags[gi])
                );
            end
        end
    endgenerate

    // buffer-state bits follow the buffers, writes to them ignored
    assign flagView = {rwFlags[7:6], rxFull_q, ~txFull_q, rwFlags[3:0]};

    always_comb begin
        busState_d = busState_q;
        unique case (busState_q)
            pefr_pkg::BUS_IDLE: begin
                if (busReq) begin
                    busState_d = pefr_pkg::BUS_ACK;
                end
            end
            pefr_pkg::BUS_ACK: begin
                busState_d = pefr_pkg::BUS_HOLD;
            end
            pefr_pkg::BUS_HOLD: begin
                busState_d = pefr_pkg::BUS_IDLE;
            end
            default: begin
                busState_d = pefr_pkg::BUS_IDLE;
            end
        endcase
    end

    // hold state gives the master a cycle to drop its request
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            busState_q <= pefr_pkg::BUS_IDLE;
            waitReq_q <= 1'b1;
        end else if (clkEn) begin
            busState_q <= busState_d;
            waitReq_q <= ~(busState_d == pefr_pkg::BUS_ACK);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            readData_q <= `PEFR_UNMAPPED_DATA;
        end else if (clkEn && busState_d == pefr_pkg::BUS_ACK && avs_read) begin
            readData_q <= selFlags ? {24'h000000, flagView} :
                          selRx ? {24'h000000, rxBuf_q} :
                          selTx ? {24'h000000, txBuf_q} : `PEFR_UNMAPPED_DATA;
        end
    end

    // receive holding buffer
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rxFull_q <= 1'b0;
            rxBuf_q <= 8'h00;
            rxTaken_q <= 1'b0;
        end else if (clkEn) begin
            rxTaken_q <= rxLoad;
            if (rxLoad) begin
                rxFull_q <= 1'b1;
                rxBuf_q <= rxDataIn;
            end else if (rxRead) begin
                rxFull_q <= 1'b0;
            end
        end
    end

    // transmit holding buffer; a write into a full buffer is dropped unless the buffer drains in the same cycle
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            txFull_q <= 1'b0;
            txBuf_q <= 8'h00;
        end else if (clkEn) begin
            if (txWrite && (!txFull_q || txDrain)) begin
                txFull_q <= 1'b1;
                txBuf_q <= avs_writedata[7:0];
            end else if (txDrain) begin
                txFull_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            flagsOut_q <= `PEFR_FLAGS_RESET;
        end else if (clkEn) begin
            flagsOut_q <= flagView;
        end
    end

    assign avs_readdata = readData_q;
    assign avs_waitrequest = waitReq_q;
    assign rxDataTaken = rxTaken_q;
    assign txDataValid = txFull_q;
    assign txDataOut = txBuf_q;
    assign flagsOut = flagsOut_q;

    property p_gate_fall;
        @(posedge clock) disable iff (!rst_b)
        (clkEn && $past(clkEn) && $past(rst_b) && $past(gateValue) && !gateValue) |=>
            rwFlags[`PEFR_BIT_GATE];
    endproperty
    a_gate_fall: assert property (p_gate_fall) else $error("gate fall lost");

    property p_conv_set;
        @(posedge clock) disable iff (!rst_b)
        (clkEn && conversionDone) |=> rwFlags[`PEFR_BIT_CONV];
    endproperty
    a_conv_set: assert property (p_conv_set) else $error("conversion flag not set");

    property p_set_wins;
        @(posedge clock) disable iff (!rst_b)
        (clkEn && counterOverflow && clearReqs[`PEFR_BIT_OVERFLOW]) |=> rwFlags[`PEFR_BIT_OVERFLOW];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat set");

    property p_sticky;
        @(posedge clock) disable iff (!rst_b)
        (rwFlags[`PEFR_BIT_PERIOD] && !clearReqs[`PEFR_BIT_PERIOD]) |=>
            rwFlags[`PEFR_BIT_PERIOD];
    endproperty
    a_sticky: assert property (p_sticky) else $error("period flag dropped");

    property p_serial_set;
        @(posedge clock) disable iff (!rst_b)
        (clkEn && serialPortDone) |=> rwFlags[`PEFR_BIT_SERIAL];
    endproperty
    a_serial_set: assert property (p_serial_set) else $error("serial flag not set");

    property p_pwm_quiet;
        @(posedge clock) disable iff (!rst_b)
        (ccpMode == pefr_pkg::CCP_PWM && !rwFlags[`PEFR_BIT_CAPCMP]) |=>
            !rwFlags[`PEFR_BIT_CAPCMP];
    endproperty
    a_pwm_quiet: assert property (p_pwm_quiet) else $error("ccp set in pwm");

    property p_rx_clear;
        @(posedge clock) disable iff (!rst_b)
        (rxRead && !rxDataReady) |=> !flagView[`PEFR_BIT_RXFULL];
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("rx full not cleared");

    property p_tx_clear;
        @(posedge clock) disable iff (!rst_b)
        (txWrite && !txFull_q) |=> !flagView[`PEFR_BIT_TXEMPTY];
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("tx empty not cleared");

    property p_ovf_set;
        @(posedge clock) disable iff (!rst_b)
        (clkEn && counterOverflow) |=> rwFlags[`PEFR_BIT_OVERFLOW] ##1 flagsOut_q[0] || !clkEn;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow not set");

    property p_tx_drop;
        @(posedge clock) disable iff (!rst_b)
        (txWrite && txFull_q && !txDrain) |=> $stable(txBuf_q) && txFull_q;
    endproperty
    a_tx_drop: assert property (p_tx_drop) else $error("full tx write landed");

    property p_clear_write;
        @(posedge clock) disable iff (!rst_b)
        (flagWrite && !conversionDone && !avs_writedata[`PEFR_BIT_CONV]) |=>
            !rwFlags[`PEFR_BIT_CONV];
    endproperty
    a_clear_write: assert property (p_clear_write) else $error("zero write kept flag");

    // no disable here: the reset state itself is what is watched
    property p_reset_state;
        @(posedge clock)
        !rst_b |=> avs_waitrequest && flagsOut_q == `PEFR_FLAGS_RESET && rwFlags == 8'h00;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

    sequence s_rx_arrive;
        clkEn && rxDataReady && !rxFull_q;
    endsequence
    property p_rx_load;
        @(posedge clock) disable iff (!rst_b)
        s_rx_arrive |=> rxFull_q && rxDataTaken && rxBuf_q == $past(rxDataIn);
    endproperty
    a_rx_load: assert property (p_rx_load) else $error("rx byte not taken");

    // read data are captured on the edge that opens the access
    sequence s_flag_read;
        clkEn && avs_read && selFlags && busState_q == pefr_pkg::BUS_IDLE;
    endsequence
    property p_flag_read;
        @(posedge clock) disable iff (!rst_b)
        s_flag_read |=> avs_readdata == {24'h000000, $past(flagView)};
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag read data wrong");

    sequence s_req_taken;
        busReq && busState_q == pefr_pkg::BUS_IDLE && clkEn;
    endsequence
    property p_bus_answer;
        @(posedge clock) disable iff (!rst_b)
        s_req_taken |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("no bus answer");
endmodule : pefr_flags
`default_nettype wire

// ===== testbench/pefr_far_end.sv
`timescale 1ns/100ps
`default_nettype none
module pefr_far_end #(
    parameter int STALL = 15
) (
    input wire logic clock,
    input wire logic rst_b,
    output logic rxDataReady,
    output logic [7:0] rxDataIn,
    input wire logic rxDataTaken,
    input wire logic txDataValid,
    input wire logic [7:0] txDataOut,
    output logic txDataTaken,
    output logic [7:0] lastTx
);
    logic [7:0] rxByte = 8'h00;
    int waitCnt;
    // idle data line shows the inverse so a stale byte cannot pass
    assign rxDataIn = rxDataReady ? rxByte : ~rxByte;
    initial rxDataReady = 1'b0;
    task automatic send_rx(input logic [7:0] b);
        rxByte <= b;
        rxDataReady <= 1'b1;
        do @(posedge clock); while (rxDataTaken !== 1'b1);
        rxDataReady <= 1'b0;
    endtask : send_rx
    // slow sink: holds the byte STALL+1 cycles before draining
    always @(posedge clock) begin
        if (!rst_b) begin
            txDataTaken <= 1'b0;
            waitCnt <= 0;
            lastTx <= 8'h00;
        end else if (txDataValid && !txDataTaken) begin
            if (waitCnt == STALL) begin
                txDataTaken <= 1'b1;
                lastTx <= txDataOut;
                waitCnt <= 0;
            end else begin
                waitCnt <= waitCnt + 1;
            end
        end else begin
            txDataTaken <= 1'b0;
        end
    end
endmodule : pefr_far_end
`default_nettype wire

// ===== testbench/peripheral_irq_flag_register_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "pefr_defs.svh"
module peripheral_irq_flag_register_test;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic gateValue = 1'b0;
    logic clkEn = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [3:0] be = 4'h0;
    logic [5:0] ev = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] got;
    logic waitReq, rxDataReady, rxDataTaken, txDataValid, txDataTaken;
    logic [7:0] rxDataIn, txDataOut, flagsOut, lastTx;
    pefr_pkg::pefr_ccp_mode_t ccpMode = pefr_pkg::CCP_CAPTURE;
    logic [7:0] evBit [6] = '{8'h40, 8'h08, 8'h04, 8'h04, 8'h02, 8'h01};
    int badCount = 0;
    int checks = 0;
    int cycles = 0;

    pefr_flags u_dut (.clock(clock), .rst_b(rst_b), .clkEn(clkEn), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(waitReq), .gateValue(gateValue),
        .conversionDone(ev[0]), .serialPortDone(ev[1]), .ccpMode(ccpMode),
        .captureEvent(ev[2]), .compareMatch(ev[3]), .periodMatch(ev[4]),
        .counterOverflow(ev[5]), .rxDataReady(rxDataReady), .rxDataIn(rxDataIn),
        .rxDataTaken(rxDataTaken), .txDataValid(txDataValid), .txDataOut(txDataOut),
        .txDataTaken(txDataTaken), .flagsOut(flagsOut));
    pefr_far_end u_far (.clock(clock), .rst_b(rst_b), .rxDataReady(rxDataReady),
        .rxDataIn(rxDataIn), .rxDataTaken(rxDataTaken), .txDataValid(txDataValid),
        .txDataOut(txDataOut), .txDataTaken(txDataTaken), .lastTx(lastTx));

    always #5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            badCount++;
            finish_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            badCount++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    // extra idle edge keeps the next request off the release step
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= {24'h0, d};
        be <= 4'hF;
        rd <= !w;
        wr <= w;
        do @(posedge clock); while (waitReq !== 1'b0);
        got = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clock);
    endtask : bus

    task automatic rd_flags(input string name, input logic [7:0] exp);
        bus(1'b0, `PEFR_FLAGS_ADDR, 8'h00);
        check(name, got, {24'h0, exp});
    endtask : rd_flags

    task automatic t_reset;
        rd_flags("flags after reset", 8'h10);
        bus(1'b0, 4'hC, 8'h00);
        check("unmapped read", got, 32'h0);
    endtask : t_reset

    task automatic t_events;
        for (int i = 0; i < 6; i++) begin
            ccpMode <= (i == 3) ? pefr_pkg::CCP_COMPARE : pefr_pkg::CCP_CAPTURE;
            ev <= 6'h01 << i;
            @(posedge clock);
            ev <= 6'h00;
            repeat (3) @(posedge clock);
            rd_flags("event flag", evBit[i] | 8'h10);
            bus(1'b1, `PEFR_FLAGS_ADDR, ~evBit[i]);
            rd_flags("flag cleared", 8'h10);
        end
        ccpMode <= pefr_pkg::CCP_PWM;
        ev <= 6'h0C;
        @(posedge clock);
        ev <= 6'h00;
        rd_flags("pwm no set", 8'h10);
    endtask : t_events

    task automatic t_gate;
        gateValue <= 1'b1;
        repeat (2) @(posedge clock);
        rd_flags("gate rise", 8'h10);
        gateValue <= 1'b0;
        repeat (2) @(posedge clock);
        rd_flags("gate fall", 8'h90);
        bus(1'b1, `PEFR_FLAGS_ADDR, 8'h7F);
        rd_flags("gate clear", 8'h10);
    endtask : t_gate

    task automatic t_write;
        ccpMode <= pefr_pkg::CCP_CAPTURE;
        ev <= 6'h37;
        @(posedge clock);
        ev <= 6'h00;
        bus(1'b1, `PEFR_FLAGS_ADDR, 8'hFF);
        rd_flags("write ones", 8'h5F);
        check("flags mirror", {24'h0, flagsOut}, 32'h5F);
        bus(1'b1, `PEFR_FLAGS_ADDR, 8'h00);
        rd_flags("write zeros", 8'h10);
        // set lands on the very edge that the clearing write completes
        fork
            bus(1'b1, `PEFR_FLAGS_ADDR, 8'h00);
            begin
                @(negedge waitReq);
                ev <= 6'h21;
                @(posedge clock);
                ev <= 6'h00;
            end
        join
        rd_flags("set beats clear", 8'h51);
        bus(1'b1, `PEFR_FLAGS_ADDR, 8'h00);
    endtask : t_write

    // an event pulse while frozen is lost, not deferred
    task automatic t_freeze;
        clkEn <= 1'b0;
        ev <= 6'h01;
        @(posedge clock);
        ev <= 6'h00;
        @(posedge clock);
        clkEn <= 1'b1;
        rd_flags("frozen event", 8'h10);
    endtask : t_freeze

    task automatic t_rx;
        u_far.send_rx(8'hA5);
        rd_flags("rx full", 8'h30);
        bus(1'b0, `PEFR_RXDATA_ADDR, 8'h00);
        check("rx data", got, 32'hA5);
        rd_flags("rx read clears", 8'h10);
    endtask : t_rx

    task automatic t_tx;
        bus(1'b1, `PEFR_TXDATA_ADDR, 8'h3C);
        rd_flags("tx full", 8'h00);
        bus(1'b1, `PEFR_TXDATA_ADDR, 8'h77);
        for (int n = 0; n < 40 && txDataValid !== 1'b0; n++) @(posedge clock);
        repeat (4) @(posedge clock);
        check("tx drained", {31'h0, txDataValid}, 32'h0);
        check("tx byte", {24'h0, lastTx}, 32'h3C);
        rd_flags("tx empty", 8'h10);
    endtask : t_tx

    initial begin
        repeat (12) @(posedge clock);
        check("waitrequest in reset", {31'h0, waitReq}, 32'h1);
        rst_b <= 1'b1;
        @(posedge clock);
        t_reset();
        t_events();
        t_gate();
        t_write();
        t_freeze();
        t_rx();
        t_tx();
        finish_test();
    end
endmodule : peripheral_irq_flag_register_test
`default_nettype wire
